// [pwm_status_pkg.sv]
// constants shared by the pwm generator status block: register map,
// field positions, reset values and time-base states.
// assumes a 32-bit AHB-Lite register window of 32 bytes.
package pwm_status_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_CTRL     = 8'h04;
  localparam logic [7:0] OFS_PERIOD   = 8'h08;
  localparam logic [7:0] OFS_DUTY     = 8'h0C;
  localparam logic [7:0] OFS_CAPVAL   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_DUTY_ACT = 8'h1C;

  // pwm_generator_status fields
  localparam int STAT_CAP    = 5;
  localparam int STAT_UPDATE = 4;
  localparam int STAT_DATA_UPDATE_REQUEST = 3;
  localparam int STAT_OUTPUT_STEERING_PHASE  = 2;
  localparam int STAT_HALF   = 1;
  localparam int STAT_CYCLE_TRIGGERED_STATUS   = 0;

  // control fields; the software trigger bit is a write-only pulse
  localparam int CTRL_W        = 4;
  localparam int CTRL_EN       = 0;
  localparam int CTRL_CENTER   = 1;
  localparam int CTRL_PUSHPULL = 2;
  localparam int CTRL_CONT     = 3;
  localparam int CTRL_SWTRIG   = 4;

  // interrupt status and mask fields
  localparam int IRQ_W   = 3;
  localparam int IRQ_CAP = 0;
  localparam int IRQ_UPD = 1;
  localparam int IRQ_CYC = 2;

  // time base width and reset values
  localparam int TB_W = 16;
  localparam logic [TB_W-1:0]   PERIOD_RST = 16'h00FF;
  localparam logic [TB_W-1:0]   DUTY_RST   = 16'h0080;
  localparam logic [CTRL_W-1:0] CTRL_RST   = 4'h0;
  localparam logic [IRQ_W-1:0]  MASK_RST   = 3'h0;

  // reset release depth
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    TB_IDLE,
    TB_UP,
    TB_DOWN
  } tb_state_e;

endpackage

// [reset_release.sv]
// reset release: asserts at once, deasserts after two clock edges.
// assumes arst_n_i may be asynchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
module reset_release (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  output var  logic rst_n_o
);
  logic [pwm_status_pkg::SYNC_STAGES-1:0] chain_reg;

  // the first stage only feeds the second, never any other logic
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= {chain_reg[pwm_status_pkg::SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign rst_n_o = chain_reg[pwm_status_pkg::SYNC_STAGES-1];
endmodule
`default_nettype wire

// [sticky_flag.sv]
// one sticky event bit, cleared by writing a one; a set wins over a clear.
// assumes clr_i is a one-cycle write strobe from the register bus.
`timescale 1ns/10ps
`default_nettype none
module sticky_flag (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output var  logic flag_o
);
  logic flag_reg;
  logic flag_next;

  // set beats clear so an event in the clearing cycle is kept
  always_comb begin
    flag_next = flag_reg;
    if (set_i) begin
      flag_next = 1'b1;
    end else if (clr_i) begin
      flag_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;
endmodule
`default_nettype wire

// [pwm_generator_status_flags.sv]
// pwm generator with its status register, data update and capture logic.
// assumes a single AHB-Lite master with this block as the only slave.
// What this block does
// - capture flag set once time base latched
// - writing one to capture flag starts capture
// - no further captures while capture flag set
// - pending update shows flag, blocks data writes
// - writing update request bit makes update pending
// - update request bit always reads zero
// - steering bit marks second push-pull cycle
// - half bit marks second center-aligned half
// - trigger bit high while cycle runs
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pwm_generator_status_flags (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output var  logic [31:0] hrdata_o,
  output var  logic        hreadyout_o,
  output var  logic        hresp_o,
  input  wire logic        ext_cycle_triggered_status_i,
  input  wire logic        cap_cycle_triggered_status_i,
  output var  logic        pwm_h_o,
  output var  logic        pwm_l_o,
  output var  logic        irq_o
);
  localparam int W = pwm_status_pkg::TB_W;

  logic                  rst_n;
  // bus state
  logic                  wr_reg;
  logic                  wr_next;
  logic [7:0]            addr_reg;
  logic [7:0]            addr_next;
  logic [31:0]           hrdata_reg;
  logic [31:0]           hrdata_next;
  logic                  hready_reg;
  logic                  acc;
  logic                  map_hit;
  // software registers
  logic [pwm_status_pkg::CTRL_W-1:0] ctrl_reg;
  logic [pwm_status_pkg::CTRL_W-1:0] ctrl_next;
  logic [W-1:0]          period_reg;
  logic [W-1:0]          period_next;
  logic [W-1:0]          duty_reg;
  logic [W-1:0]          duty_next;
  logic [W-1:0]          period_act_reg;
  logic [W-1:0]          period_act_next;
  logic [W-1:0]          duty_act_reg;
  logic [W-1:0]          duty_act_next;
  logic [pwm_status_pkg::IRQ_W-1:0]  mask_reg;
  logic [pwm_status_pkg::IRQ_W-1:0]  mask_next;
  logic [pwm_status_pkg::IRQ_W-1:0]  irq_stat;
  // time base
  pwm_status_pkg::tb_state_e state_reg;
  pwm_status_pkg::tb_state_e state_next;
  logic [W-1:0]          cnt_reg;
  logic [W-1:0]          cnt_next;
  logic                  output_steering_phase_reg;
  logic                  output_steering_phase_next;
  logic                  pwm_h_reg;
  logic                  pwm_h_next;
  logic                  pwm_l_reg;
  logic                  pwm_l_next;
  logic                  irq_reg;
  logic                  irq_next;
  // status flags
  logic                  cap_reg;
  logic                  cap_next;
  logic                  cap_req_reg;
  logic                  cap_req_next;
  logic [W-1:0]          capval_reg;
  logic [W-1:0]          capval_next;
  logic                  upd_pend_reg;
  logic                  upd_pend_next;
  // strobes
  logic                  stat_wr;
  logic                  ctrl_wr;
  logic                  cycle_triggered_status;
  logic                  cyc_start;
  logic                  cyc_end;
  logic                  boundary;
  logic                  cap_event;
  logic                  upd_set;
  logic                  transfer;
  logic                  pwm_on;

  reset_release u_reset_release (
    .clk_i    (ref_clk_i),
    .arst_n_i (arst_n_i),
    .rst_n_o  (rst_n)
  );

  // address phase decode; only the low byte selects within the window
  assign acc     = hsel_i & htrans_i[1] & hready_i;
  assign map_hit = (haddr_i[31:5] == 27'h0000000);
  assign stat_wr = wr_reg & (addr_reg == pwm_status_pkg::OFS_STATUS);
  assign ctrl_wr = wr_reg & (addr_reg == pwm_status_pkg::OFS_CTRL);

  // read data is picked in the address phase so the slave needs no wait states
  always_comb begin
    wr_next     = acc & hwrite_i & map_hit;
    addr_next   = acc ? {haddr_i[7:2], 2'b00} : addr_reg;
    hrdata_next = 32'h00000000;
    if (acc & !hwrite_i & map_hit) begin
      unique case ({haddr_i[7:2], 2'b00})
        pwm_status_pkg::OFS_STATUS: begin
          hrdata_next[pwm_status_pkg::STAT_CAP]    = cap_reg;
          hrdata_next[pwm_status_pkg::STAT_UPDATE] = upd_pend_reg;
          hrdata_next[pwm_status_pkg::STAT_DATA_UPDATE_REQUEST] = 1'b0;
          hrdata_next[pwm_status_pkg::STAT_OUTPUT_STEERING_PHASE]  = output_steering_phase_reg
            & ctrl_reg[pwm_status_pkg::CTRL_PUSHPULL];
          hrdata_next[pwm_status_pkg::STAT_HALF]   = ctrl_reg[pwm_status_pkg::CTRL_CENTER]
            & (state_reg == pwm_status_pkg::TB_DOWN);
          hrdata_next[pwm_status_pkg::STAT_CYCLE_TRIGGERED_STATUS]   =
            (state_reg != pwm_status_pkg::TB_IDLE);
        end
        pwm_status_pkg::OFS_CTRL:     hrdata_next = {28'h0000000, ctrl_reg};
        pwm_status_pkg::OFS_PERIOD:   hrdata_next = {16'h0000, period_reg};
        pwm_status_pkg::OFS_DUTY:     hrdata_next = {16'h0000, duty_reg};
        pwm_status_pkg::OFS_CAPVAL:   hrdata_next = {16'h0000, capval_reg};
        pwm_status_pkg::OFS_IRQ_STAT: hrdata_next = {29'h00000000, irq_stat};
        pwm_status_pkg::OFS_IRQ_MASK: hrdata_next = {29'h00000000, mask_reg};
        pwm_status_pkg::OFS_DUTY_ACT: hrdata_next = {16'h0000, duty_act_reg};
        default:                      hrdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg     <= 1'b0;
      addr_reg   <= 8'h00;
      hrdata_reg <= 32'h00000000;
      hready_reg <= 1'b0;
    end else begin
      wr_reg     <= wr_next;
      addr_reg   <= addr_next;
      hrdata_reg <= hrdata_next;
      hready_reg <= 1'b1;
    end
  end

  assign hrdata_o    = hrdata_reg;
  assign hreadyout_o = hready_reg;
  assign hresp_o     = 1'b0;

  // software registers; data registers are frozen while an update is pending
  always_comb begin
    ctrl_next       = ctrl_reg;
    period_next     = period_reg;
    duty_next       = duty_reg;
    mask_next       = mask_reg;
    period_act_next = period_act_reg;
    duty_act_next   = duty_act_reg;
    if (ctrl_wr) begin
      ctrl_next = hwdata_i[pwm_status_pkg::CTRL_W-1:0];
    end
    if (wr_reg & (addr_reg == pwm_status_pkg::OFS_PERIOD) & !upd_pend_reg) begin
      period_next = hwdata_i[W-1:0];
    end
    if (wr_reg & (addr_reg == pwm_status_pkg::OFS_DUTY) & !upd_pend_reg) begin
      duty_next = hwdata_i[W-1:0];
    end
    if (wr_reg & (addr_reg == pwm_status_pkg::OFS_IRQ_MASK)) begin
      mask_next = hwdata_i[pwm_status_pkg::IRQ_W-1:0];
    end
    if (transfer) begin
      period_act_next = period_reg;
      duty_act_next   = duty_reg;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg       <= pwm_status_pkg::CTRL_RST;
      period_reg     <= pwm_status_pkg::PERIOD_RST;
      duty_reg       <= pwm_status_pkg::DUTY_RST;
      mask_reg       <= pwm_status_pkg::MASK_RST;
      period_act_reg <= pwm_status_pkg::PERIOD_RST;
      duty_act_reg   <= pwm_status_pkg::DUTY_RST;
    end else begin
      ctrl_reg       <= ctrl_next;
      period_reg     <= period_next;
      duty_reg       <= duty_next;
      mask_reg       <= mask_next;
      period_act_reg <= period_act_next;
      duty_act_reg   <= duty_act_next;
    end
  end

  // time base: edge mode counts up to period, center mode up then down
  assign cycle_triggered_status = ctrl_reg[pwm_status_pkg::CTRL_EN]
              & (ext_cycle_triggered_status_i | (ctrl_wr & hwdata_i[pwm_status_pkg::CTRL_SWTRIG]));
  assign cyc_end = ((state_reg == pwm_status_pkg::TB_UP) & (cnt_reg == period_act_reg)
                    & !(ctrl_reg[pwm_status_pkg::CTRL_CENTER] & (cnt_reg != {W{1'b0}})))
                 | ((state_reg == pwm_status_pkg::TB_DOWN) & (cnt_reg == {W{1'b0}}));
  assign cyc_start = ((state_reg == pwm_status_pkg::TB_IDLE) & cycle_triggered_status)
                   | (cyc_end & ctrl_reg[pwm_status_pkg::CTRL_CONT]
                      & ctrl_reg[pwm_status_pkg::CTRL_EN]);
  // idle counts as a boundary so an update never waits for a cycle that never runs
  assign boundary = cyc_end | (state_reg == pwm_status_pkg::TB_IDLE);
  assign pwm_on   = (state_reg != pwm_status_pkg::TB_IDLE) & (cnt_reg < duty_act_reg);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    output_steering_phase_next = output_steering_phase_reg;
    unique case (state_reg)
      pwm_status_pkg::TB_IDLE: begin
        cnt_next = {W{1'b0}};
      end
      pwm_status_pkg::TB_UP: begin
        if (cyc_end) begin
          state_next = pwm_status_pkg::TB_IDLE;
        end else if (cnt_reg == period_act_reg) begin
          state_next = pwm_status_pkg::TB_DOWN;
          cnt_next   = cnt_reg - 16'h0001;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      pwm_status_pkg::TB_DOWN: begin
        if (cyc_end) begin
          state_next = pwm_status_pkg::TB_IDLE;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      default: begin
        state_next = pwm_status_pkg::TB_IDLE;
      end
    endcase
    // a cycle start restarts the count whatever the state did above;
    // steering follows the mode being written, so the first pair cycle reads as the first
    if (cyc_start) begin
      state_next = pwm_status_pkg::TB_UP;
      cnt_next   = {W{1'b0}};
      if (ctrl_next[pwm_status_pkg::CTRL_PUSHPULL]) begin
        output_steering_phase_next = !output_steering_phase_reg;
      end
    end
    if (!ctrl_reg[pwm_status_pkg::CTRL_EN]) begin
      state_next = pwm_status_pkg::TB_IDLE;
    end
    // leaving push-pull parks steering so the next pair starts on the first cycle
    if (!ctrl_next[pwm_status_pkg::CTRL_PUSHPULL]) begin
      output_steering_phase_next = 1'b1;
    end
    pwm_h_next = pwm_on & !(ctrl_reg[pwm_status_pkg::CTRL_PUSHPULL] & output_steering_phase_reg);
    pwm_l_next = pwm_on & ctrl_reg[pwm_status_pkg::CTRL_PUSHPULL] & output_steering_phase_reg;
    irq_next   = |(irq_stat & mask_reg);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pwm_status_pkg::TB_IDLE;
      cnt_reg   <= {W{1'b0}};
      output_steering_phase_reg <= 1'b1;
      pwm_h_reg <= 1'b0;
      pwm_l_reg <= 1'b0;
      irq_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      output_steering_phase_reg <= output_steering_phase_next;
      pwm_h_reg <= pwm_h_next;
      pwm_l_reg <= pwm_l_next;
      irq_reg   <= irq_next;
    end
  end

  assign pwm_h_o = pwm_h_reg;
  assign pwm_l_o = pwm_l_reg;
  assign irq_o   = irq_reg;

  // capture and update flags
  assign cap_event = !cap_reg & (cap_req_reg | cap_cycle_triggered_status_i);
  assign upd_set   = stat_wr & hwdata_i[pwm_status_pkg::STAT_DATA_UPDATE_REQUEST];
  assign transfer  = upd_pend_reg & boundary;

  always_comb begin
    cap_next      = cap_reg;
    cap_req_next  = cap_req_reg;
    capval_next   = capval_reg;
    upd_pend_next = upd_pend_reg;
    // writing zero clears the flag; writing one asks for a software capture
    if (stat_wr & !hwdata_i[pwm_status_pkg::STAT_CAP]) begin
      cap_next = 1'b0;
    end
    if (stat_wr & hwdata_i[pwm_status_pkg::STAT_CAP] & !cap_reg) begin
      cap_req_next = 1'b1;
    end
    if (cap_event) begin
      cap_next     = 1'b1;
      cap_req_next = 1'b0;
      capval_next  = cnt_reg;
    end
    if (transfer) begin
      upd_pend_next = 1'b0;
    end
    // a fresh request beats the clearing boundary
    if (upd_set) begin
      upd_pend_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cap_reg      <= 1'b0;
      cap_req_reg  <= 1'b0;
      capval_reg   <= {W{1'b0}};
      upd_pend_reg <= 1'b0;
    end else begin
      cap_reg      <= cap_next;
      cap_req_reg  <= cap_req_next;
      capval_reg   <= capval_next;
      upd_pend_reg <= upd_pend_next;
    end
  end

  // interrupt sources: capture done, update applied, cycle started
  logic [pwm_status_pkg::IRQ_W-1:0] irq_set;
  logic                             irq_clr_wr;
  assign irq_set[pwm_status_pkg::IRQ_CAP] = cap_event;
  assign irq_set[pwm_status_pkg::IRQ_UPD] = transfer;
  assign irq_set[pwm_status_pkg::IRQ_CYC] = cyc_start;
  assign irq_clr_wr = wr_reg & (addr_reg == pwm_status_pkg::OFS_IRQ_STAT);

  for (genvar i = 0; i < pwm_status_pkg::IRQ_W; i++) begin : g_irq
    sticky_flag u_sticky_flag (
      .clk_i   (ref_clk_i),
      .rst_n_i (rst_n),
      .set_i   (irq_set[i]),
      .clr_i   (irq_clr_wr & hwdata_i[i]),
      .flag_o  (irq_stat[i])
    );
  end

  // checks
  chk_cap_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    cap_event |=> cap_reg && (capval_reg == $past(cnt_reg)))
    else $error("capture flag or value not taken");

  chk_cap_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $rose(cap_reg) |-> $past(cap_event))
    else $error("capture flag rose with no capture");

  chk_sw_capture: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (stat_wr && hwdata_i[pwm_status_pkg::STAT_CAP] && !cap_reg) |-> ##[1:2] cap_reg)
    else $error("software capture request not served");

  chk_cap_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (cap_reg && !stat_wr) |=> cap_reg && $stable(capval_reg))
    else $error("capture taken while flag set");

  chk_upd_block: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (upd_pend_reg && wr_reg && (addr_reg == pwm_status_pkg::OFS_DUTY)) |=> $stable(duty_reg))
    else $error("data register written while update pending");

  chk_upd_request: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    upd_set |=> upd_pend_reg)
    else $error("update request not made pending");

  chk_data_update_request_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $past(acc && !hwrite_i && map_hit && (haddr_i[7:0] == pwm_status_pkg::OFS_STATUS))
      |-> !hrdata_o[pwm_status_pkg::STAT_DATA_UPDATE_REQUEST])
    else $error("update request bit read back as one");

  chk_output_steering_phase_out: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    pwm_l_o |-> $past(output_steering_phase_reg && ctrl_reg[pwm_status_pkg::CTRL_PUSHPULL]))
    else $error("second push-pull output outside second cycle");

  chk_half_mode: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $rose(state_reg == pwm_status_pkg::TB_DOWN) |-> $past(ctrl_reg[pwm_status_pkg::CTRL_CENTER]))
    else $error("second half entered outside center mode");

  chk_cycle_triggered_status_run: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ((state_reg == pwm_status_pkg::TB_IDLE) && cycle_triggered_status) |=> (state_reg == pwm_status_pkg::TB_UP))
    else $error("trigger did not start a cycle");

  chk_upd_done: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (transfer && !upd_set) |=> !upd_pend_reg && (duty_act_reg == $past(duty_reg)))
    else $error("pending update not applied at boundary");

  chk_output_steering_phase_flip: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (cyc_start && ctrl_next[pwm_status_pkg::CTRL_PUSHPULL]) |=> (output_steering_phase_reg != $past(output_steering_phase_reg)))
    else $error("steering did not toggle at cycle start");

endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the pwm generator status block over AHB-Lite:
// reset values, update, capture, trigger, half-cycle, steering and interrupt.
// assumes a single master; the block's hreadyout_o is fed back as hready_i.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %0h want %0h", $time, (g), (e)); end end
module tb;
  localparam logic [7:0] A_ST = pwm_status_pkg::OFS_STATUS;
  localparam logic [7:0] A_CT = pwm_status_pkg::OFS_CTRL;
  localparam logic [7:0] A_PE = pwm_status_pkg::OFS_PERIOD;
  localparam logic [7:0] A_DU = pwm_status_pkg::OFS_DUTY;
  localparam logic [7:0] A_CV = pwm_status_pkg::OFS_CAPVAL;
  localparam logic [7:0] A_IS = pwm_status_pkg::OFS_IRQ_STAT;
  localparam logic [7:0] A_MK = pwm_status_pkg::OFS_IRQ_MASK;
  localparam logic [7:0] A_DA = pwm_status_pkg::OFS_DUTY_ACT;
  logic        ref_clk_i  = 1'b0;
  logic        arst_n_i   = 1'b0;
  logic        hsel_i     = 1'b0;
  logic [31:0] haddr_i    = 32'h0;
  logic [1:0]  htrans_i   = 2'h0;
  logic        hwrite_i   = 1'b0;
  logic [31:0] hwdata_i   = 32'h0;
  logic        ext_cycle_triggered_status_i = 1'b0;
  logic        cap_cycle_triggered_status_i = 1'b0;
  wire  [31:0] hrdata_o;
  wire         hreadyout_o;
  wire         hresp_o;
  wire         pwm_h_o;
  wire         pwm_l_o;
  wire         irq_o;
  int          bad_count   = 0;
  int          check_count = 0;
  int          seed        = 32'hC0A1931E;
  logic [63:0] exp_q[$];
  logic [63:0] note;
  logic        rd_phase = 1'b0;
  logic        seen_l   = 1'b0;
  logic        seen_h   = 1'b0;
  logic        ok;
  logic [31:0] rd;
  logic [31:0] c1;
  logic [31:0] v;

  pwm_generator_status_flags i_pwm_generator_status_flags (
    .ref_clk_i   (ref_clk_i),
    .arst_n_i    (arst_n_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (3'h2),
    .hready_i    (hreadyout_o),
    .hwdata_i    (hwdata_i),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .ext_cycle_triggered_status_i  (ext_cycle_triggered_status_i),
    .cap_cycle_triggered_status_i  (cap_cycle_triggered_status_i),
    .pwm_h_o     (pwm_h_o),
    .pwm_l_o     (pwm_l_o),
    .irq_o       (irq_o)
  );

  // 40 MHz clock
  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // one single transfer; address phase held until hready, data phase likewise
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= {24'h0, a};
    hwrite_i <= w;
    @(posedge ref_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= w ? d : 32'h0;
    @(posedge ref_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
    rd = hrdata_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // read with a note of the expected bits; a zero mask just fetches
  task automatic rdx(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back({m, e});
    xfer(1'b0, a, 32'h0);
  endtask

  // poll a status bit for a bounded number of reads
  task automatic poll(input int b, input logic want, input int n);
    ok = 1'b0;
    repeat (n) if (!ok) begin
      rdx(A_ST, 32'h0, 32'h0);
      if (rd[b] === want) ok = 1'b1;
    end
  endtask

  // stop cleanly before a mode change so the time base restarts from idle
  task automatic start(input logic [31:0] ctl);
    wr(A_CT, 32'h1);
    poll(pwm_status_pkg::STAT_CYCLE_TRIGGERED_STATUS, 1'b0, 40);
    wr(A_CT, ctl);
  endtask

  task automatic pulse_cap();
    @(posedge ref_clk_i);
    cap_cycle_triggered_status_i <= 1'b1;
    @(posedge ref_clk_i);
    cap_cycle_triggered_status_i <= 1'b0;
  endtask

  // read data is compared at the edge that ends the data phase
  always @(posedge ref_clk_i) begin
    if (rd_phase && hreadyout_o === 1'b1) begin
      note = exp_q.pop_front();
      `CHK(hrdata_o & note[63:32], note[31:0])
      `CHK(hresp_o, 1'b0)
    end
    if (hreadyout_o === 1'b1) rd_phase <= hsel_i && htrans_i[1] && !hwrite_i;
    if (pwm_l_o === 1'b1) seen_l <= 1'b1;
    if (pwm_h_o === 1'b1) seen_h <= 1'b1;
  end

  task automatic final_report();
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // the whole sequence needs a few hundred cycles
  initial begin
    #(25 * 20000);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    rdx(A_ST, '1, 32'h0);
    rdx(A_CT, '1, 32'h0);
    rdx(A_PE, '1, 32'hFF);
    rdx(A_DU, '1, 32'h80);
    rdx(A_MK, '1, 32'h0);
    rdx(8'h40, '1, 32'h0);
    // idle: data writes land, an update request loads them at once
    repeat (4) begin
      // a zero duty would keep both outputs low for the rest of the run
      v = {16'h0, 16'($random(seed))} | 32'h1;
      wr(A_DU, v);
      rdx(A_DU, '1, v);
    end
    wr(A_PE, 32'h20);
    wr(A_ST, 32'h08);
    repeat (4) @(posedge ref_clk_i);
    rdx(A_DA, '1, v);
    rdx(A_ST, 32'h18, 32'h0);
    // running: pending update blocks data writes until the cycle ends
    // enable first: the trigger in a control write needs the enable already set
    wr(A_CT, 32'h1);
    wr(A_CT, 32'h19);
    wr(A_ST, 32'h08);
    rdx(A_ST, 32'h19, 32'h11);
    wr(A_PE, 32'h40);
    rdx(A_PE, '1, 32'h20);
    poll(pwm_status_pkg::STAT_UPDATE, 1'b0, 40);
    `CHK(ok, 1'b1)
    rdx(A_IS, 32'h2, 32'h2);
    wr(A_IS, 32'h7);
    // hardware capture, then suppression while the flag stands
    wr(A_MK, 32'h1);
    pulse_cap();
    rdx(A_ST, 32'h20, 32'h20);
    rdx(A_CV, 32'h0, 32'h0);
    c1 = rd;
    `CHK(irq_o, 1'b1)
    repeat (5) @(posedge ref_clk_i);
    pulse_cap();
    rdx(A_CV, '1, c1);
    wr(A_IS, 32'h1);
    repeat (3) @(posedge ref_clk_i);
    `CHK(irq_o, 1'b0)
    wr(A_ST, 32'h0);
    rdx(A_ST, 32'h20, 32'h0);
    // software capture with the interrupt masked, then unmasked
    wr(A_MK, 32'h0);
    wr(A_ST, 32'h20);
    rdx(A_ST, 32'h20, 32'h20);
    `CHK(irq_o, 1'b0)
    wr(A_MK, 32'h1);
    repeat (3) @(posedge ref_clk_i);
    `CHK(irq_o, 1'b1)
    wr(A_IS, 32'h1);
    wr(A_ST, 32'h0);
    // one-shot cycle ends, an external trigger starts another
    wr(A_CT, 32'h1);
    poll(pwm_status_pkg::STAT_CYCLE_TRIGGERED_STATUS, 1'b0, 40);
    rdx(A_ST, 32'h1, 32'h0);
    @(posedge ref_clk_i);
    ext_cycle_triggered_status_i <= 1'b1;
    @(posedge ref_clk_i);
    ext_cycle_triggered_status_i <= 1'b0;
    rdx(A_ST, 32'h1, 32'h1);
    // center-aligned halves, then edge mode never shows half or steering
    start(32'h1B);
    poll(pwm_status_pkg::STAT_HALF, 1'b1, 40);
    `CHK(ok, 1'b1)
    poll(pwm_status_pkg::STAT_HALF, 1'b0, 40);
    `CHK(ok, 1'b1)
    start(32'h19);
    repeat (12) rdx(A_ST, 32'h6, 32'h0);
    // push-pull pairs alternate the steering phase
    start(32'h1D);
    rdx(A_ST, 32'h5, 32'h1);
    poll(pwm_status_pkg::STAT_OUTPUT_STEERING_PHASE, 1'b1, 40);
    `CHK(ok, 1'b1)
    poll(pwm_status_pkg::STAT_OUTPUT_STEERING_PHASE, 1'b0, 40);
    `CHK(ok, 1'b1)
    `CHK(seen_l, 1'b1)
    `CHK(seen_h, 1'b1)
    final_report();
  end
endmodule
`default_nettype wire
